/* File: tb.sv */
// testbench: directed tests for the 8-bit timer
`timescale 1ns/1ns
module tb
   import tc8_pkg::*;
;
   logic clk_i, reset_n_i, timer_power_off_bit_i, external_count_pin_i;
   logic [2:0] clock_select_field_i, waveform_mode_field_i;
   logic [1:0] compare_output_mode_a_i, compare_output_mode_b_i;
   logic count_wr_i, compare_a_wr_i, compare_b_wr_i, flag_wr_i;
   logic [7:0] count_wdata_i, compare_wdata_i, count_value_o, v, m;
   logic force_compare_strobe_a_i, force_compare_strobe_b_i;
   logic [2:0] flag_wdata_i, timer_mask_register_i, timer_flag_register_o;
   logic overflow_ack_i, compare_a_ack_i, compare_b_ack_i;
   logic [7:0] compare_a_value_o, compare_b_value_o;
   logic overflow_irq_o, compare_a_irq_o, compare_b_irq_o;
   logic compare_output_a_o, compare_output_b_o, bottom_o, max_o, top_o;
   int bad_count, num_checks, cyc;

   tc8_timer tc8_timer_i (.*);

   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e)
      begin
         bad_count++;
         $display("Error at %0t: saw %h want %h", $time, s, e);
      end
   endtask : chk

   // strobes rise and fall on falling edges only
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk_i);
      s = 1'b0;
   endtask : pulse

   task automatic wcnt(input logic [7:0] d);
      count_wdata_i = d;
      pulse(count_wr_i);
   endtask : wcnt

   task automatic till(input logic [7:0] c, input int n);
      int k;
      k = 0;
      while (count_value_o !== c && k < n)
      begin
         @(negedge clk_i);
         k++;
      end
      chk(count_value_o, c);
   endtask : till

   task automatic fwait(input int b);
      repeat (10)
         if (timer_flag_register_o[b] !== 1'b1)
            @(negedge clk_i);
      chk(8'(timer_flag_register_o[b]), 8'h01);
   endtask : fwait

   task print_verdict;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   // ceiling well above the longest test, a full pwm period included
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         bad_count++;
         print_verdict();
      end
   end

   initial
   begin
      {reset_n_i, timer_power_off_bit_i, external_count_pin_i,
         clock_select_field_i, waveform_mode_field_i, count_wr_i,
         compare_output_mode_a_i, compare_output_mode_b_i,
         compare_a_wr_i, compare_b_wr_i, flag_wr_i, count_wdata_i,
         compare_wdata_i, force_compare_strobe_a_i, flag_wdata_i,
         force_compare_strobe_b_i, overflow_ack_i, compare_a_ack_i,
         compare_b_ack_i} = '0;
      timer_mask_register_i = 3'h7;
      bad_count = 0;
      num_checks = 0;
      cyc = 0;
      repeat (5) @(negedge clk_i);
      reset_n_i = 1'b1;
      chk(count_value_o, 8'h00);
      chk(8'({max_o, bottom_o}), 8'h01);
      chk(8'(timer_flag_register_o), 8'h00);
      $display("end reset");
      wcnt(8'hff);
      chk(8'(max_o), 8'h01);
      repeat (3) @(negedge clk_i);
      chk(count_value_o, 8'hff);
      $display("end stop");
      clock_select_field_i = 3'h1;
      till(8'h00, 4);
      chk(8'(timer_flag_register_o[0]), 8'h01);
      chk(8'(overflow_irq_o), 8'h01);
      timer_mask_register_i = 3'h6;
      @(negedge clk_i);
      chk(8'(overflow_irq_o), 8'h00);
      clock_select_field_i = 3'h0;
      // late match events from count zero must land before the clear
      repeat (2) @(negedge clk_i);
      flag_wdata_i = 3'h7;
      pulse(flag_wr_i);
      chk(8'(timer_flag_register_o), 8'h00);
      $display("end overflow");
      timer_mask_register_i = 3'h7;
      compare_wdata_i = 8'h40;
      pulse(compare_a_wr_i);
      chk(compare_a_value_o, 8'h40);
      wcnt(8'h3d);
      clock_select_field_i = 3'h1;
      fwait(1);
      chk(8'(compare_a_irq_o), 8'h01);
      pulse(compare_a_ack_i);
      chk(8'(timer_flag_register_o[1]), 8'h00);
      $display("end compare a");
      clock_select_field_i = 3'h0;
      compare_wdata_i = 8'h50;
      pulse(compare_b_wr_i);
      chk(compare_b_value_o, 8'h50);
      wcnt(8'h50);
      clock_select_field_i = 3'h1;
      repeat (6) @(negedge clk_i);
      chk(8'(timer_flag_register_o[2]), 8'h00);
      wcnt(8'h4e);
      fwait(2);
      chk(8'(compare_b_irq_o), 8'h01);
      pulse(compare_b_ack_i);
      $display("end blocking");
      clock_select_field_i = 3'h0;
      chk(8'(compare_output_a_o), 8'h00);
      compare_output_mode_a_i = TC8_COM_TOGGLE;
      compare_output_mode_b_i = TC8_COM_SET;
      pulse(force_compare_strobe_a_i);
      pulse(force_compare_strobe_b_i);
      chk(8'({compare_output_b_o, compare_output_a_o}), 8'h03);
      chk(8'(timer_flag_register_o), 8'h00);
      waveform_mode_field_i = TC8_WGM_FAST_FF;
      pulse(force_compare_strobe_a_i);
      chk(8'(compare_output_a_o), 8'h01);
      $display("end force");
      compare_output_mode_a_i = TC8_COM_CLEAR;
      compare_wdata_i = 8'h20;
      pulse(compare_a_wr_i);
      wcnt(8'h18);
      clock_select_field_i = 3'h1;
      till(8'h30, 30);
      chk(8'(timer_flag_register_o[1]), 8'h00);
      till(8'h10, 300);
      chk(8'(compare_output_a_o), 8'h01);
      flag_wdata_i = 3'h2;
      pulse(flag_wr_i);
      till(8'h24, 30);
      chk(8'(timer_flag_register_o[1]), 8'h01);
      chk(8'(compare_output_a_o), 8'h00);
      $display("end fast pwm");
      clock_select_field_i = 3'h0;
      waveform_mode_field_i = TC8_WGM_CTC;
      compare_wdata_i = 8'h05;
      pulse(compare_a_wr_i);
      wcnt(8'h00);
      clock_select_field_i = 3'h1;
      m = 8'h00;
      repeat (20)
      begin
         @(negedge clk_i);
         if (count_value_o > m)
            m = count_value_o;
         if (count_value_o == 8'h05)
            chk(8'(top_o), 8'h01);
      end
      chk(m, 8'h05);
      $display("end ctc");
      timer_power_off_bit_i = 1'b1;
      @(negedge clk_i);
      v = count_value_o;
      repeat (4) @(negedge clk_i);
      chk(count_value_o, v);
      timer_power_off_bit_i = 1'b0;
      $display("end power");
      clock_select_field_i = TC8_CS_STOP;
      waveform_mode_field_i = TC8_WGM_NORMAL;
      wcnt(8'h80);
      clock_select_field_i = TC8_CS_EXT_RISE;
      repeat (3)
      begin
         external_count_pin_i = 1'b1;
         repeat (2) @(negedge clk_i);
         external_count_pin_i = 1'b0;
         repeat (2) @(negedge clk_i);
      end
      chk(count_value_o, 8'h83);
      clock_select_field_i = TC8_CS_EXT_FALL;
      external_count_pin_i = 1'b1;
      repeat (2) @(negedge clk_i);
      external_count_pin_i = 1'b0;
      repeat (2) @(negedge clk_i);
      chk(count_value_o, 8'h84);
      clock_select_field_i = TC8_CS_STOP;
      @(negedge clk_i);
      clock_select_field_i = 3'h2;
      repeat (16) @(negedge clk_i);
      chk(count_value_o, 8'h86);
      $display("end clock source");
      clock_select_field_i = TC8_CS_STOP;
      waveform_mode_field_i = TC8_WGM_PHASE_FF;
      flag_wdata_i = 3'h7;
      pulse(flag_wr_i);
      wcnt(8'hfd);
      clock_select_field_i = 3'h1;
      repeat (4) @(negedge clk_i);
      chk(count_value_o, 8'hfd);
      wcnt(8'h02);
      repeat (3) @(negedge clk_i);
      chk(count_value_o, 8'h01);
      chk(8'(timer_flag_register_o[0]), 8'h01);
      $display("end phase pwm");
      print_verdict();
   end
endmodule : tb

/* File: tc8_compare_unit.sv */
// compare unit: double buffered value, match and output state
`timescale 1ns/1ns
module tc8_compare_unit
   import tc8_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [7:0] count_value_i,
   input wire logic pwm_mode_i,
   input wire logic fast_pwm_i,
   input wire logic update_point_i,
   input wire logic at_bottom_i,
   input wire logic tick_i,
   input wire logic block_i,
   input wire logic [1:0] compare_output_mode_i,
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   input wire logic force_compare_strobe_i,
   output logic [7:0] compare_value_o,
   output logic [7:0] buffer_value_o,
   output logic match_o,
   output logic match_event_o,
   output logic compare_output_o
);
   logic [7:0] active;
   logic [7:0] buffer;
   logic oc;
   logic [7:0] next_active;
   logic [7:0] next_buffer;
   logic next_oc;
   logic hit;

   always_comb
   begin
      match_o = (count_value_i == active);
      hit = match_o && tick_i && !block_i;
      next_active = active;
      next_buffer = buffer;
      next_oc = oc;
      if (wr_i)
      begin
         if (pwm_mode_i)
            next_buffer = wdata_i;
         else
         begin
            next_active = wdata_i;
            next_buffer = wdata_i;
         end
      end
      if (pwm_mode_i && update_point_i && tick_i)
         next_active = wr_i ? wdata_i : buffer;
      // mode bits act at once, never buffered
      if (!pwm_mode_i)
      begin
         if (hit || force_compare_strobe_i)
         begin
            case (compare_output_mode_i)
               TC8_COM_TOGGLE: next_oc = !oc;
               TC8_COM_CLEAR: next_oc = 1'b0;
               TC8_COM_SET: next_oc = 1'b1;
               default: next_oc = oc;
            endcase
         end
      end
      else if (fast_pwm_i && compare_output_mode_i[1])
      begin
         // match wins over bottom so a zero duty stays flat
         // non-inverting clears on match and sets at bottom
         if (hit)
            next_oc = compare_output_mode_i[0];
         else if (at_bottom_i && tick_i)
            next_oc = !compare_output_mode_i[0];
      end
      else if (hit && compare_output_mode_i[1])
         next_oc = compare_output_mode_i[0];
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         active <= TC8_CMP_RESET;
         buffer <= TC8_CMP_RESET;
         oc <= 1'b0;
         match_event_o <= 1'b0;
      end
      else
      begin
         active <= next_active;
         buffer <= next_buffer;
         oc <= next_oc;
         match_event_o <= hit;
      end
   end

   assign compare_value_o = active;
   assign buffer_value_o = buffer;
   assign compare_output_o = oc;
endmodule : tc8_compare_unit

/* File: tc8_pkg.sv */
// package: constants and types for the 8-bit dual compare timer
package tc8_pkg;
   localparam logic [7:0] TC8_BOTTOM = 8'h00;
   localparam logic [7:0] TC8_MAX = 8'hff;
   localparam logic [7:0] TC8_COUNT_RESET = 8'h00;
   localparam logic [7:0] TC8_CMP_RESET = 8'h00;
   localparam logic [2:0] TC8_CS_STOP = 3'h0;
   localparam logic [2:0] TC8_CS_EXT_FALL = 3'h6;
   localparam logic [2:0] TC8_CS_EXT_RISE = 3'h7;
   localparam logic [2:0] TC8_WGM_NORMAL = 3'h0;
   localparam logic [2:0] TC8_WGM_PHASE_FF = 3'h1;
   localparam logic [2:0] TC8_WGM_CTC = 3'h2;
   localparam logic [2:0] TC8_WGM_FAST_FF = 3'h3;
   localparam logic [2:0] TC8_WGM_PHASE_A = 3'h5;
   localparam logic [2:0] TC8_WGM_FAST_A = 3'h7;
   localparam logic [1:0] TC8_COM_OFF = 2'h0;
   localparam logic [1:0] TC8_COM_TOGGLE = 2'h1;
   localparam logic [1:0] TC8_COM_CLEAR = 2'h2;
   localparam logic [1:0] TC8_COM_SET = 2'h3;
   localparam int TC8_PRESCALE_W = 10;
   localparam logic [9:0] TC8_PRE_RESET = 10'h000;
   typedef enum logic [1:0] {TC8_CNT_HOLD, TC8_CNT_UP, TC8_CNT_DOWN,
      TC8_CNT_CLEAR} tc8_cnt_op_t;
endpackage : tc8_pkg

/* File: tc8_tick_gen.sv */
// tick generator: prescaler taps and external pin edge select
`timescale 1ns/1ns
module tc8_tick_gen
   import tc8_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic enable_i,
   input wire logic [2:0] clock_select_field_i,
   input wire logic external_count_pin_i,
   output logic timer_clock_tick_o
);
   logic [TC8_PRESCALE_W-1:0] pre;
   logic [TC8_PRESCALE_W-1:0] next_pre;
   logic pin_q;
   logic next_pin_q;
   logic tick;

   always_comb
   begin
      next_pin_q = external_count_pin_i;
      // prescaler free-runs only while a source is selected
      if (!enable_i || clock_select_field_i == TC8_CS_STOP)
         next_pre = TC8_PRE_RESET;
      else
         next_pre = pre + 10'h001;
      tick = 1'b0;
      if (enable_i)
      begin
         case (clock_select_field_i)
            3'h1: tick = 1'b1;
            3'h2: tick = (pre[2:0] == 3'h7);
            3'h3: tick = (pre[5:0] == 6'h3f);
            3'h4: tick = (pre[7:0] == 8'hff);
            3'h5: tick = (pre == 10'h3ff);
            TC8_CS_EXT_FALL: tick = pin_q && !external_count_pin_i;
            TC8_CS_EXT_RISE: tick = !pin_q && external_count_pin_i;
            default: tick = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pre <= TC8_PRE_RESET;
         pin_q <= 1'b0;
      end
      else
      begin
         pre <= next_pre;
         pin_q <= next_pin_q;
      end
   end

   assign timer_clock_tick_o = tick;
endmodule : tc8_tick_gen

/* File: tc8_timer.sv */
// top: 8-bit timer/counter with two compare units and flags
// Notes on behaviour
// - zero count signals bottom
// - 0xff is the maximum count
// - top is 0xff or compare a
// - clock select zero stops the counter
// - tick from prescaler or external pin edge
// - tick clears, counts up or down per mode
// - cpu count write beats clear and count
// - both compare values matched continuously
// - match sets flag one clock after the next tick
// - flag cleared by service or writing one
// - three flags, each gated by mask bit
// - overflow flag set per mode
// - compare buffering only in pwm modes
// - buffered value loads at top
// - cpu writes reach buffer when buffering
// - force strobe acts like match outside pwm modes, no flag
// - count write blocks matches next tick
// - output state kept across mode change
// - output mode bits act immediately
// - power-off bit high disables timer
// - mode 0 wraps, overflow when zero
// - mode 2 clears on compare a
// - fast pwm set/clear at bottom and match
// - output mode zero leaves output alone
`timescale 1ns/1ns
module tc8_timer
   import tc8_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic timer_power_off_bit_i,
   input wire logic [2:0] clock_select_field_i,
   input wire logic [2:0] waveform_mode_field_i,
   input wire logic [1:0] compare_output_mode_a_i,
   input wire logic [1:0] compare_output_mode_b_i,
   input wire logic external_count_pin_i,
   input wire logic count_wr_i,
   input wire logic [7:0] count_wdata_i,
   input wire logic compare_a_wr_i,
   input wire logic compare_b_wr_i,
   input wire logic [7:0] compare_wdata_i,
   input wire logic force_compare_strobe_a_i,
   input wire logic force_compare_strobe_b_i,
   input wire logic flag_wr_i,
   input wire logic [2:0] flag_wdata_i,
   input wire logic [2:0] timer_mask_register_i,
   input wire logic overflow_ack_i,
   input wire logic compare_a_ack_i,
   input wire logic compare_b_ack_i,
   output logic [7:0] count_value_o,
   output logic [7:0] compare_a_value_o,
   output logic [7:0] compare_b_value_o,
   output logic [2:0] timer_flag_register_o,
   output logic overflow_irq_o,
   output logic compare_a_irq_o,
   output logic compare_b_irq_o,
   output logic compare_output_a_o,
   output logic compare_output_b_o,
   output logic bottom_o,
   output logic max_o,
   output logic top_o
);
   logic enable;
   logic tick;
   logic [7:0] count;
   logic [7:0] next_count;
   logic down;
   logic next_down;
   logic blocked;
   logic next_blocked;
   logic overflow_flag;
   logic compare_a_flag;
   logic compare_b_flag;
   logic next_overflow_flag;
   logic next_compare_a_flag;
   logic next_compare_b_flag;
   logic [7:0] top;
   logic pwm_mode;
   logic fast_pwm;
   logic phase_pwm;
   logic at_top;
   logic at_bottom;
   logic update_point;
   logic ov_set;
   logic match_a;
   logic match_b;
   logic event_a;
   logic event_b;
   logic [7:0] buf_a;
   logic [7:0] buf_b;
   logic [7:0] act_a;
   logic [7:0] act_b;
   logic force_a;
   logic force_b;
   tc8_cnt_op_t op;
   logic [2:0] flag_set;
   logic [2:0] flag_clear;

   assign enable = !timer_power_off_bit_i;

   tc8_tick_gen u_tick
   (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .enable_i(enable),
      .clock_select_field_i(clock_select_field_i),
      .external_count_pin_i(external_count_pin_i),
      .timer_clock_tick_o(tick)
   );

   always_comb
   begin
      fast_pwm = 1'b0;
      phase_pwm = 1'b0;
      top = TC8_MAX;
      case (waveform_mode_field_i)
         TC8_WGM_NORMAL:
            top = TC8_MAX;
         TC8_WGM_PHASE_FF:
            phase_pwm = 1'b1;
         TC8_WGM_CTC:
            top = act_a;
         TC8_WGM_FAST_FF:
            fast_pwm = 1'b1;
         TC8_WGM_PHASE_A:
         begin
            phase_pwm = 1'b1;
            top = act_a;
         end
         TC8_WGM_FAST_A:
         begin
            fast_pwm = 1'b1;
            top = act_a;
         end
         // modes 4 and 6 count up to the fixed maximum
         default:
            top = TC8_MAX;
      endcase
      pwm_mode = fast_pwm || phase_pwm;
      at_top = (count == top);
      at_bottom = (count == TC8_BOTTOM);
      // both pwm kinds reload the compare value at top
      update_point = at_top;
   end

   // strobes only act outside the pwm modes
   always_comb
   begin
      force_a = 1'b0;
      force_b = 1'b0;
      if (enable && !pwm_mode)
      begin
         force_a = force_compare_strobe_a_i;
         force_b = force_compare_strobe_b_i;
      end
   end

   tc8_compare_unit u_cmp_a
   (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .count_value_i(count),
      .pwm_mode_i(pwm_mode),
      .fast_pwm_i(fast_pwm),
      .update_point_i(update_point),
      .at_bottom_i(at_bottom),
      .tick_i(tick),
      .block_i(blocked),
      .compare_output_mode_i(compare_output_mode_a_i),
      .wr_i(compare_a_wr_i),
      .wdata_i(compare_wdata_i),
      .force_compare_strobe_i(force_a),
      .compare_value_o(act_a),
      .buffer_value_o(buf_a),
      .match_o(match_a),
      .match_event_o(event_a),
      .compare_output_o(compare_output_a_o)
   );

   tc8_compare_unit u_cmp_b
   (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .count_value_i(count),
      .pwm_mode_i(pwm_mode),
      .fast_pwm_i(fast_pwm),
      .update_point_i(update_point),
      .at_bottom_i(at_bottom),
      .tick_i(tick),
      .block_i(blocked),
      .compare_output_mode_i(compare_output_mode_b_i),
      .wr_i(compare_b_wr_i),
      .wdata_i(compare_wdata_i),
      .force_compare_strobe_i(force_b),
      .compare_value_o(act_b),
      .buffer_value_o(buf_b),
      .match_o(match_b),
      .match_event_o(event_b),
      .compare_output_o(compare_output_b_o)
   );

   // counter sequencing per waveform mode
   always_comb
   begin
      op = TC8_CNT_HOLD;
      next_down = down;
      ov_set = 1'b0;
      if (tick)
      begin
         case (waveform_mode_field_i)
            TC8_WGM_NORMAL:
            begin
               op = TC8_CNT_UP;
               ov_set = (count == TC8_MAX);
            end
            TC8_WGM_CTC:
            begin
               op = at_top ? TC8_CNT_CLEAR : TC8_CNT_UP;
               ov_set = (count == TC8_MAX);
            end
            TC8_WGM_FAST_FF, TC8_WGM_FAST_A:
            begin
               op = at_top ? TC8_CNT_CLEAR : TC8_CNT_UP;
               ov_set = at_top;
            end
            TC8_WGM_PHASE_FF, TC8_WGM_PHASE_A:
            begin
               // dual slope: turn at top, overflow at bottom
               if (at_top)
                  next_down = 1'b1;
               else if (at_bottom)
                  next_down = 1'b0;
               // a top of zero would otherwise wrap to the maximum
               if (at_top && at_bottom)
                  op = TC8_CNT_HOLD;
               else if (at_top || (down && !at_bottom))
                  op = TC8_CNT_DOWN;
               else
                  op = TC8_CNT_UP;
               ov_set = at_bottom;
            end
            default:
            begin
               // modes 4 and 6 only count up, with no overflow
               op = TC8_CNT_UP;
            end
         endcase
      end
      case (op)
         TC8_CNT_UP: next_count = count + 8'h01;
         TC8_CNT_DOWN: next_count = count - 8'h01;
         TC8_CNT_CLEAR: next_count = TC8_BOTTOM;
         default: next_count = count;
      endcase
      // a cpu write outranks any clear or count
      if (count_wr_i)
      begin
         next_count = count_wdata_i;
         // block lasts until the next tick has passed
         next_blocked = 1'b1;
      end
      else if (tick)
         next_blocked = 1'b0;
      else
         next_blocked = blocked;
      if (!enable)
      begin
         next_count = count;
         next_blocked = blocked;
      end
   end

   // clear sources: service ack or a one written to the bit
   always_comb
   begin
      flag_clear[0] = overflow_ack_i || (flag_wr_i && flag_wdata_i[0]);
      flag_clear[1] = compare_a_ack_i || (flag_wr_i && flag_wdata_i[1]);
      flag_clear[2] = compare_b_ack_i || (flag_wr_i && flag_wdata_i[2]);
      flag_set[0] = ov_set && enable;
      flag_set[1] = event_a;
      flag_set[2] = event_b;
   end

   // flags: hardware set wins over clear
   always_comb
   begin
      next_overflow_flag = overflow_flag;
      next_compare_a_flag = compare_a_flag;
      next_compare_b_flag = compare_b_flag;
      if (flag_clear[0])
         next_overflow_flag = 1'b0;
      if (flag_clear[1])
         next_compare_a_flag = 1'b0;
      if (flag_clear[2])
         next_compare_b_flag = 1'b0;
      if (flag_set[0])
         next_overflow_flag = 1'b1;
      if (flag_set[1])
         next_compare_a_flag = 1'b1;
      if (flag_set[2])
         next_compare_b_flag = 1'b1;
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         count <= TC8_COUNT_RESET;
         down <= 1'b0;
         blocked <= 1'b0;
         overflow_flag <= 1'b0;
         compare_a_flag <= 1'b0;
         compare_b_flag <= 1'b0;
      end
      else
      begin
         count <= next_count;
         down <= next_down;
         blocked <= next_blocked;
         overflow_flag <= next_overflow_flag;
         compare_a_flag <= next_compare_a_flag;
         compare_b_flag <= next_compare_b_flag;
      end
   end

   assign count_value_o = count;
   // cpu reads the register it would write
   assign compare_a_value_o = pwm_mode ? buf_a : act_a;
   assign compare_b_value_o = pwm_mode ? buf_b : act_b;
   assign timer_flag_register_o = {compare_b_flag, compare_a_flag,
      overflow_flag};
   // each request gated by its own mask bit
   assign overflow_irq_o = overflow_flag && timer_mask_register_i[0];
   assign compare_a_irq_o = compare_a_flag && timer_mask_register_i[1];
   assign compare_b_irq_o = compare_b_flag && timer_mask_register_i[2];
   assign bottom_o = at_bottom;
   assign max_o = (count == TC8_MAX);
   assign top_o = at_top;
endmodule : tc8_timer

/* File: tc8_timer_assertions.sv */
// checker: port assertions for the 8-bit timer
`timescale 1ns/1ns
module tc8_timer_chk
   import tc8_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic timer_power_off_bit_i,
   input wire logic [2:0] clock_select_field_i,
   input wire logic [2:0] waveform_mode_field_i,
   input wire logic count_wr_i,
   input wire logic [7:0] count_wdata_i,
   input wire logic flag_wr_i,
   input wire logic [2:0] flag_wdata_i,
   input wire logic [2:0] timer_mask_register_i,
   input wire logic overflow_ack_i,
   input wire logic [7:0] count_value_o,
   input wire logic [2:0] timer_flag_register_o,
   input wire logic overflow_irq_o,
   input wire logic compare_a_irq_o,
   input wire logic compare_b_irq_o,
   input wire logic bottom_o,
   input wire logic max_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   AST_BOTTOM: assert property (
      bottom_o == (count_value_o == TC8_BOTTOM))
      else $error("bottom flag wrong");
   AST_MAX: assert property (
      max_o == (count_value_o == TC8_MAX))
      else $error("max flag wrong");
   AST_STOP: assert property (
      clock_select_field_i == TC8_CS_STOP && !count_wr_i
      |=> $stable(count_value_o))
      else $error("count moved while stopped");
   AST_WRITE: assert property (
      count_wr_i && !timer_power_off_bit_i
      |=> count_value_o == $past(count_wdata_i))
      else $error("count write lost");
   AST_IRQ: assert property (
      {compare_b_irq_o, compare_a_irq_o, overflow_irq_o}
      == (timer_flag_register_o & timer_mask_register_i))
      else $error("request not flag and mask");
   AST_HOLD: assert property (
      timer_flag_register_o[0] && !overflow_ack_i
      && !(flag_wr_i && flag_wdata_i[0])
      |=> timer_flag_register_o[0])
      else $error("overflow flag dropped");
   // cs held two samples: the tick path may lag a select change
   AST_WRAP: assert property (
      waveform_mode_field_i == TC8_WGM_NORMAL
      && count_value_o == TC8_MAX && clock_select_field_i == 3'h1
      && $past(clock_select_field_i) == 3'h1 && !count_wr_i
      && !timer_power_off_bit_i && !$past(timer_power_off_bit_i)
      |=> count_value_o == TC8_BOTTOM && timer_flag_register_o[0])
      else $error("no wrap with overflow");
   AST_POWER: assert property (
      timer_power_off_bit_i |=> $stable(count_value_o))
      else $error("count moved while powered off");

   cover property ($rose(timer_flag_register_o[0]));
   cover property ($rose(timer_flag_register_o[1]));
   cover property ($rose(timer_flag_register_o[2]));
endmodule : tc8_timer_chk

bind tc8_timer tc8_timer_chk tc8_timer_chk_i (.*);
